// >>> rtl/eirq_map.svh
// register offsets, field positions and reset values of the interrupt source block
`ifndef EIRQ_MAP_SVH
`define EIRQ_MAP_SVH

`define EIRQ_ADDR_MAIN        4'h0
`define EIRQ_ADDR_CTL2        4'h1
`define EIRQ_ADDR_CTL3        4'h2
`define EIRQ_ADDR_TCTL        4'h3
`define EIRQ_ADDR_TLO         4'h4
`define EIRQ_ADDR_THI         4'h5
`define EIRQ_ADDR_EVST        4'h6
`define EIRQ_ADDR_EVMSK       4'h7
`define EIRQ_ADDR_CORE        4'h8

`define EIRQ_MAIN_GIE         7
`define EIRQ_MAIN_T0IE        5
`define EIRQ_MAIN_X0IE        4
`define EIRQ_MAIN_PCIE        3
`define EIRQ_MAIN_T0IF        2
`define EIRQ_MAIN_X0IF        1
`define EIRQ_MAIN_PCIF        0
`define EIRQ_MAIN_WMASK       8'hBF

`define EIRQ_CTL2_POL_LSB     4
`define EIRQ_CTL2_T0PRI       2
`define EIRQ_CTL2_X3PRI       1
`define EIRQ_CTL2_PCPRI       0
`define EIRQ_CTL2_WMASK       8'hF7

`define EIRQ_CTL3_X2PRI       7
`define EIRQ_CTL3_X1PRI       6
`define EIRQ_CTL3_IE_LSB      3
`define EIRQ_CTL3_IF_LSB      0

`define EIRQ_TCTL_RUN         7
`define EIRQ_TCTL_MODE8       6
`define EIRQ_TCTL_WMASK       8'hC0

`define EIRQ_EV_EXT_LSB       0
`define EIRQ_EV_T0            4
`define EIRQ_EV_PC            5
`define EIRQ_EV_ENTRY         6

`define EIRQ_CORE_FULL        7

`define EIRQ_RST_MAIN         8'h00
`define EIRQ_RST_CTL2         8'hF7
`define EIRQ_RST_CTL3         8'hC0
`define EIRQ_RST_TCTL         8'h40
`define EIRQ_RST_EVMSK        8'h00

`endif

// >>> rtl/eirq_pkg.sv
// shared types of the interrupt source block
package eirq_pkg;
    typedef logic [7:0] eirq_byte_t;

    typedef struct packed {
        eirq_byte_t working;
        eirq_byte_t status;
        eirq_byte_t bank;
    } eirq_ctx_t;
endpackage

// >>> rtl/eirq_edge.sv
// two-flop pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module eirq_edge #(
    parameter int W = 8
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_pins,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } eirq_edge_st_t;

    eirq_edge_st_t r_reg;
    eirq_edge_st_t r_next;

    // s1 feeds only s2; edges are judged between s2 and s3
    always_comb begin
        r_next      = r_reg;
        r_next.s1   = i_pins;
        r_next.s2   = r_reg.s1;
        r_next.s3   = r_reg.s2;
        r_next.rise = r_reg.s2 & ~r_reg.s3;
        r_next.fall = ~r_reg.s2 & r_reg.s3;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rise = r_reg.rise;
    assign o_fall = r_reg.fall;
endmodule
`default_nettype wire

// >>> rtl/eirq_top.sv
// edge, timer-zero and port-change interrupt sources with entry context save
// Operation
// - external pins trigger on edges, never levels
// - polarity bit one rising, zero falling
// - valid edge sets that pin's flag
// - no request while pin enable is clear
// - flags stay set until software clears
// - enabled external pins wake from sleep
// - vector after wake only with global enable
// - pins one to three have priority bits
// - pin zero always high priority
// - 8-bit timer overflow FFh to 00h flags
// - 16-bit timer overflow FFFFh to 0000h flags
// - timer enable main bit5, priority two bit2
// - port B 7:4 change sets main bit0
// - port change enable bit3, priority two bit0
// - entry pushes return counter on stack
// - entry copies working, status, bank to shadow
`timescale 1ns/1ps
`default_nettype none
`include "eirq_map.svh"
module eirq_top #(
    parameter int PCW   = 21,
    parameter int DEPTH = 31
) (
    input  wire logic           i_mclk,
    input  wire logic           i_resetn,
    input  wire logic [7:0]     i_port_b_pins,
    input  wire logic [3:0]     i_addr,
    input  wire logic [7:0]     i_wdata,
    input  wire logic           i_wr,
    input  wire logic           i_rd,
    output logic      [7:0]     o_rdata,
    input  wire logic           i_sleep,
    input  wire logic           i_irq_enter,
    input  wire logic           i_irq_return,
    input  wire logic [PCW-1:0] i_return_pc,
    input  wire logic [7:0]     i_working_register,
    input  wire logic [7:0]     i_status_reg,
    input  wire logic [7:0]     i_bank_select_register,
    output logic                o_irq_high,
    output logic                o_irq_low,
    output logic                o_wake,
    output logic                o_irq,
    output logic [PCW-1:0]      o_return_pc,
    output logic [7:0]          o_shadow_working,
    output logic [7:0]          o_shadow_status,
    output logic [7:0]          o_shadow_bank,
    output logic                o_stack_full
);
    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] SP_FULL = PW'(DEPTH);

    typedef struct packed {
        logic [7:0]                main_irq_control;
        logic [7:0]                irq_control_two;
        logic [7:0]                irq_control_three;
        logic [7:0]                tctl;
        logic [7:0]                tlo;
        logic [7:0]                thi;
        logic [7:0]                evst;
        logic [7:0]                evmsk;
        logic [7:0]                rdata;
        logic [DEPTH-1:0][PCW-1:0] stack;
        logic [PW-1:0]             sp;
        logic [PCW-1:0]            top;
        eirq_pkg::eirq_ctx_t       shadow;
        logic                      hi;
        logic                      lo;
        logic                      wake;
        logic                      irq;
        logic                      full;
    } eirq_st_t;

    localparam eirq_st_t ST_RESET = '{
        main_irq_control:  `EIRQ_RST_MAIN,
        irq_control_two:   `EIRQ_RST_CTL2,
        irq_control_three: `EIRQ_RST_CTL3,
        tctl:              `EIRQ_RST_TCTL,
        evmsk:             `EIRQ_RST_EVMSK,
        default:           '0
    };

    eirq_st_t r_reg;
    eirq_st_t r_next;

    function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] k);
        return wr && (a == k);
    endfunction

    logic [7:0] pin_rise;
    logic [7:0] pin_fall;
    logic [3:0] valid_edge;
    logic       port_chg;
    logic       ovf8;
    logic       ovf16;
    logic [5:0] pend;
    logic       any_hi;
    logic       any_lo;
    logic       global_irq_enable;
    logic       wr_main;
    logic       wr_ctl2;
    logic       wr_ctl3;

    // pins arrive from outside the clock domain
    eirq_edge #(
        .W (8)
    ) u_edge (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_pins   (i_port_b_pins),
        .o_rise   (pin_rise),
        .o_fall   (pin_fall)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            // only a transition counts, a held level never re-triggers
            assign valid_edge[gi] = r_reg.irq_control_two[`EIRQ_CTL2_POL_LSB + gi]
                                  ? pin_rise[gi] : pin_fall[gi];
        end
    endgenerate

    // any toggle of the upper four port pins
    assign port_chg = |(pin_rise[7:4] | pin_fall[7:4]);

    assign ovf8  = r_reg.tctl[`EIRQ_TCTL_RUN] && r_reg.tctl[`EIRQ_TCTL_MODE8]
                && (r_reg.tlo == 8'hFF);
    assign ovf16 = r_reg.tctl[`EIRQ_TCTL_RUN] && !r_reg.tctl[`EIRQ_TCTL_MODE8]
                && ({r_reg.thi, r_reg.tlo} == 16'hFFFF);

    assign wr_main = wr_hit(i_wr, i_addr, `EIRQ_ADDR_MAIN);
    assign wr_ctl2 = wr_hit(i_wr, i_addr, `EIRQ_ADDR_CTL2);
    assign wr_ctl3 = wr_hit(i_wr, i_addr, `EIRQ_ADDR_CTL3);
    assign global_irq_enable     = r_reg.main_irq_control[`EIRQ_MAIN_GIE];

    // a source is pending only with both flag and enable set
    assign pend[0] = r_reg.main_irq_control[`EIRQ_MAIN_X0IF]
                  && r_reg.main_irq_control[`EIRQ_MAIN_X0IE];
    assign pend[1] = r_reg.irq_control_three[`EIRQ_CTL3_IF_LSB]
                  && r_reg.irq_control_three[`EIRQ_CTL3_IE_LSB];
    assign pend[2] = r_reg.irq_control_three[`EIRQ_CTL3_IF_LSB + 1]
                  && r_reg.irq_control_three[`EIRQ_CTL3_IE_LSB + 1];
    assign pend[3] = r_reg.irq_control_three[`EIRQ_CTL3_IF_LSB + 2]
                  && r_reg.irq_control_three[`EIRQ_CTL3_IE_LSB + 2];
    assign pend[4] = r_reg.main_irq_control[`EIRQ_MAIN_T0IF]
                  && r_reg.main_irq_control[`EIRQ_MAIN_T0IE];
    assign pend[5] = r_reg.main_irq_control[`EIRQ_MAIN_PCIF]
                  && r_reg.main_irq_control[`EIRQ_MAIN_PCIE];

    // pin zero has no priority bit and always goes high
    assign any_hi = pend[0]
                 || (pend[1] && r_reg.irq_control_three[`EIRQ_CTL3_X1PRI])
                 || (pend[2] && r_reg.irq_control_three[`EIRQ_CTL3_X2PRI])
                 || (pend[3] && r_reg.irq_control_two[`EIRQ_CTL2_X3PRI])
                 || (pend[4] && r_reg.irq_control_two[`EIRQ_CTL2_T0PRI])
                 || (pend[5] && r_reg.irq_control_two[`EIRQ_CTL2_PCPRI]);
    assign any_lo = (pend[1] && !r_reg.irq_control_three[`EIRQ_CTL3_X1PRI])
                 || (pend[2] && !r_reg.irq_control_three[`EIRQ_CTL3_X2PRI])
                 || (pend[3] && !r_reg.irq_control_two[`EIRQ_CTL2_X3PRI])
                 || (pend[4] && !r_reg.irq_control_two[`EIRQ_CTL2_T0PRI])
                 || (pend[5] && !r_reg.irq_control_two[`EIRQ_CTL2_PCPRI]);

    always_comb begin
        r_next       = r_reg;
        r_next.rdata = 8'h00;

        // timer zero: 8-bit mode counts only the low byte
        if (r_reg.tctl[`EIRQ_TCTL_RUN]) begin
            if (r_reg.tctl[`EIRQ_TCTL_MODE8]) begin
                r_next.tlo = r_reg.tlo + 8'h01;
            end else begin
                {r_next.thi, r_next.tlo} = {r_reg.thi, r_reg.tlo} + 16'h0001;
            end
        end
        // a bus write to the count wins over the increment of that cycle
        if (wr_hit(i_wr, i_addr, `EIRQ_ADDR_TLO)) begin
            r_next.tlo = i_wdata;
        end
        if (wr_hit(i_wr, i_addr, `EIRQ_ADDR_THI)) begin
            r_next.thi = i_wdata;
        end
        if (wr_hit(i_wr, i_addr, `EIRQ_ADDR_TCTL)) begin
            r_next.tctl = i_wdata & `EIRQ_TCTL_WMASK;
        end

        // flags change only by a write or by their event
        if (wr_main) begin
            r_next.main_irq_control = i_wdata & `EIRQ_MAIN_WMASK;
        end
        if (wr_ctl2) begin
            r_next.irq_control_two = i_wdata & `EIRQ_CTL2_WMASK;
        end
        if (wr_ctl3) begin
            r_next.irq_control_three = i_wdata;
        end
        if (wr_hit(i_wr, i_addr, `EIRQ_ADDR_EVMSK)) begin
            r_next.evmsk = i_wdata;
        end

        // events are ORed in after the writes so a set beats a clear
        if (valid_edge[0]) begin
            r_next.main_irq_control[`EIRQ_MAIN_X0IF] = 1'b1;
        end
        r_next.irq_control_three[`EIRQ_CTL3_IF_LSB +: 3] =
            r_next.irq_control_three[`EIRQ_CTL3_IF_LSB +: 3] | valid_edge[3:1];
        if (ovf8 || ovf16) begin
            r_next.main_irq_control[`EIRQ_MAIN_T0IF] = 1'b1;
        end
        if (port_chg) begin
            r_next.main_irq_control[`EIRQ_MAIN_PCIF] = 1'b1;
        end

        // sticky event status, write one to clear
        if (wr_hit(i_wr, i_addr, `EIRQ_ADDR_EVST)) begin
            r_next.evst = r_reg.evst & ~i_wdata;
        end
        r_next.evst[`EIRQ_EV_EXT_LSB +: 4] = r_next.evst[`EIRQ_EV_EXT_LSB +: 4] | valid_edge;
        r_next.evst[`EIRQ_EV_T0]    = r_next.evst[`EIRQ_EV_T0] | ovf8 | ovf16;
        r_next.evst[`EIRQ_EV_PC]    = r_next.evst[`EIRQ_EV_PC] | port_chg;
        r_next.evst[`EIRQ_EV_ENTRY] = r_next.evst[`EIRQ_EV_ENTRY] | i_irq_enter;
        r_next.evst[7]              = 1'b0;
        r_next.irq                  = |(r_next.evst & r_next.evmsk);

        // requests to the core only with the global enable set
        r_next.hi   = global_irq_enable && any_hi;
        r_next.lo   = global_irq_enable && any_lo;
        // wake ignores the global enable; the core decides to vector
        r_next.wake = i_sleep && (|pend);

        // entry: push the return counter and shadow the context
        if (i_irq_enter) begin
            r_next.shadow.working = i_working_register;
            r_next.shadow.status  = i_status_reg;
            r_next.shadow.bank    = i_bank_select_register;
            // a push onto a full stack is dropped rather than wrapping
            if (!r_reg.full) begin
                r_next.stack[r_reg.sp] = i_return_pc;
                r_next.sp              = r_reg.sp + 1'b1;
            end
        end else if (i_irq_return && (r_reg.sp != '0)) begin
            r_next.sp = r_reg.sp - 1'b1;
        end
        r_next.full = (r_next.sp == SP_FULL);
        if (r_next.sp != '0) begin
            r_next.top = r_next.stack[PW'(r_next.sp - 1'b1)];
        end else begin
            r_next.top = '0;
        end

        // read data stand only in the cycle after the strobe
        if (i_rd) begin
            case (i_addr)
                `EIRQ_ADDR_MAIN:  r_next.rdata = r_reg.main_irq_control;
                `EIRQ_ADDR_CTL2:  r_next.rdata = r_reg.irq_control_two;
                `EIRQ_ADDR_CTL3:  r_next.rdata = r_reg.irq_control_three;
                `EIRQ_ADDR_TCTL:  r_next.rdata = r_reg.tctl;
                `EIRQ_ADDR_TLO:   r_next.rdata = r_reg.tlo;
                `EIRQ_ADDR_THI:   r_next.rdata = r_reg.thi;
                `EIRQ_ADDR_EVST:  r_next.rdata = r_reg.evst;
                `EIRQ_ADDR_EVMSK: r_next.rdata = r_reg.evmsk;
                `EIRQ_ADDR_CORE: begin
                    r_next.rdata                 = 8'(r_reg.sp);
                    r_next.rdata[`EIRQ_CORE_FULL] = r_reg.full;
                end
                default:          r_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= ST_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rdata          = r_reg.rdata;
    assign o_irq_high       = r_reg.hi;
    assign o_irq_low        = r_reg.lo;
    assign o_wake           = r_reg.wake;
    assign o_irq            = r_reg.irq;
    assign o_return_pc      = r_reg.top;
    assign o_shadow_working = r_reg.shadow.working;
    assign o_shadow_status  = r_reg.shadow.status;
    assign o_shadow_bank    = r_reg.shadow.bank;
    assign o_stack_full     = r_reg.full;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    edge_only_a:
        assert property ($rose(r_reg.main_irq_control[`EIRQ_MAIN_X0IF])
                         |-> $past(valid_edge[0]) || $past(wr_main))
        else $error("pin zero flag rose without an edge or write");
    pol_select_a:
        assert property (((pin_rise[1] && r_reg.irq_control_two[`EIRQ_CTL2_POL_LSB + 1])
                          || (pin_fall[1] && !r_reg.irq_control_two[`EIRQ_CTL2_POL_LSB + 1]))
                         |=> r_reg.irq_control_three[`EIRQ_CTL3_IF_LSB])
        else $error("pin one edge of selected polarity not flagged");
    flag_set_a:
        assert property (valid_edge[0] |=> r_reg.main_irq_control[`EIRQ_MAIN_X0IF])
        else $error("pin zero edge lost, set must beat clear");
    no_request_a:
        assert property ((pend == 6'h00) |=> !o_irq_high && !o_irq_low)
        else $error("request raised with no enabled flag");
    flag_hold_a:
        assert property (r_reg.main_irq_control[`EIRQ_MAIN_X0IF] && !wr_main
                         |=> r_reg.main_irq_control[`EIRQ_MAIN_X0IF])
        else $error("pin zero flag dropped without a write");
    wake_pin_a:
        assert property (i_sleep && pend[0] |=> o_wake)
        else $error("enabled pin zero did not wake");
    vector_gie_a:
        assert property ((o_irq_high || o_irq_low) |-> $past(global_irq_enable))
        else $error("request without global enable");

    pin1_prio_a:
        assert property ((pend == 6'h02) && global_irq_enable
                         |=> o_irq_high == $past(r_reg.irq_control_three[`EIRQ_CTL3_X1PRI]))
        else $error("pin one routed to wrong priority");

    pin0_high_a:
        assert property (pend[0] && global_irq_enable |=> o_irq_high)
        else $error("pin zero not high priority");

    tmr_eight_a:
        assert property (ovf8 |=> r_reg.main_irq_control[`EIRQ_MAIN_T0IF])
        else $error("8-bit overflow not flagged");

    tmr_sixteen_a:
        assert property (r_reg.tctl[`EIRQ_TCTL_RUN] && !r_reg.tctl[`EIRQ_TCTL_MODE8]
                         && r_reg.thi == 8'hFF && r_reg.tlo == 8'hFF
                         |=> r_reg.main_irq_control[`EIRQ_MAIN_T0IF])
        else $error("16-bit overflow not flagged");

    tmr_prio_a:
        assert property ((pend == 6'h10) && global_irq_enable
                         |=> o_irq_low == !$past(r_reg.irq_control_two[`EIRQ_CTL2_T0PRI]))
        else $error("timer routed to wrong priority");

    port_change_a:
        assert property (port_chg |=> r_reg.main_irq_control[`EIRQ_MAIN_PCIF])
        else $error("port change not flagged");

    chg_prio_a:
        assert property ((pend == 6'h20) && global_irq_enable
                         |=> o_irq_high == $past(r_reg.irq_control_two[`EIRQ_CTL2_PCPRI]))
        else $error("port change routed to wrong priority");

    stack_push_a:
        assert property (i_irq_enter && !r_reg.full
                         |=> r_reg.sp == $past(r_reg.sp) + 1'b1 && o_return_pc == $past(i_return_pc))
        else $error("return counter not pushed");
    shadow_copy_a:
        assert property (i_irq_enter
                         |=> o_shadow_working == $past(i_working_register)
                             && o_shadow_status == $past(i_status_reg)
                             && o_shadow_bank == $past(i_bank_select_register))
        else $error("context not shadowed on entry");
    late_enable_a:
        assert property ((pend == 6'h08) && global_irq_enable |=> o_irq_high || o_irq_low)
        else $error("flag set before enable gave no request");
endmodule
`default_nettype wire

// >>> verif/eirq_core_model.sv
// core-side partner model: takes interrupt entry, returns once the request is withdrawn or 64 cycles pass
`timescale 1ns/1ps
`default_nettype none
module eirq_core_model (
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_irq_high,
    input  wire logic        i_irq_low,
    input  wire logic        i_take,
    input  wire logic [3:0]  i_delay,
    output logic             o_irq_enter,
    output logic             o_irq_return,
    output logic [20:0]      o_return_pc,
    output logic [23:0]      o_ctx
);
    logic [23:0] saved_ctx;
    initial begin
        o_irq_enter = 1'h0;
        o_irq_return = 1'h0;
        o_return_pc = 21'h000100;
        o_ctx = 24'h5A3C0F;
    end
    always begin
        @(posedge i_mclk);
        if (i_resetn && i_take && (i_irq_high || i_irq_low)) begin
            repeat (i_delay) @(posedge i_mclk);
            // fresh values each entry so a stale shadow copy shows up
            o_return_pc <= o_return_pc + 21'h000104;
            o_ctx <= o_ctx + 24'h212223;
            o_irq_enter <= 1'h1;
            @(posedge i_mclk);
            o_irq_enter <= 1'h0;
            saved_ctx <= o_ctx;
            // handler waits up to 64 cycles for software to clear the flag before returning
            for (int n = 0; n < 64 && (i_irq_high || i_irq_low); n++)
                @(posedge i_mclk);
            o_irq_return <= 1'h1;
            o_ctx <= saved_ctx;
            @(posedge i_mclk);
            o_irq_return <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/edge_timer_change_irq_sources_test.sv
// self-checking bench for the interrupt source block
`timescale 1ns/1ps
`default_nettype none
`include "eirq_map.svh"
module edge_timer_change_irq_sources_test;
    logic        mclk = 1'h0;
    logic        rst_n = 1'h0;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic        slp = 1'h0;
    logic        take = 1'h0;
    logic [3:0]  dly = 4'h0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wd = 8'h00;
    logic [7:0]  pb = 8'h00;
    logic [7:0]  rdat, sw, ss, sb;
    logic [20:0] pc, opc;
    logic [23:0] ctx;
    logic        ent, ret, hi, lo, wake, irq, full;
    int          mismatches = 0;
    int          samples_checked = 0;

    eirq_top dut (.i_mclk(mclk), .i_resetn(rst_n), .i_port_b_pins(pb), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_sleep(slp),
        .i_irq_enter(ent), .i_irq_return(ret), .i_return_pc(pc),
        .i_working_register(ctx[23:16]), .i_status_reg(ctx[15:8]),
        .i_bank_select_register(ctx[7:0]), .o_irq_high(hi), .o_irq_low(lo),
        .o_wake(wake), .o_irq(irq), .o_return_pc(opc), .o_shadow_working(sw),
        .o_shadow_status(ss), .o_shadow_bank(sb), .o_stack_full(full));
    eirq_core_model core (.i_mclk(mclk), .i_resetn(rst_n), .i_irq_high(hi),
        .i_irq_low(lo), .i_take(take), .i_delay(dly), .o_irq_enter(ent),
        .o_irq_return(ret), .o_return_pc(pc), .o_ctx(ctx));

    always #10 mclk = ~mclk;

    task automatic results;
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic hang;
        mismatches++;
        $display("FAIL %0t: wait ran out", $time);
        results();
    endtask
    task automatic c(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wd <= d;
        @(posedge mclk);
        wr <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        c(rdat, e);
    endtask
    // pin change, then long enough for sync, edge register and flag
    task automatic pin(input int i, input logic v);
        @(posedge mclk);
        pb[i] <= v;
        cy(7);
    endtask
    task automatic flag(input int i, input logic f);
        if (i == 0)
            rc(`EIRQ_ADDR_MAIN, {6'h00, f, 1'h0});
        else
            rc(`EIRQ_ADDR_CTL3, 8'hC0 | (8'(f) << (i - 1)));
    endtask

    task automatic t_edges;
        for (int i = 0; i < 4; i++) begin
            for (int p = 0; p < 2; p++) begin
                w(`EIRQ_ADDR_CTL2, 8'h07 | (p[0] ? 8'h10 << i : 8'h00));
                w(`EIRQ_ADDR_MAIN, 8'h00);
                w(`EIRQ_ADDR_CTL3, 8'hC0);
                pin(i, !p[0]);
                flag(i, 1'h0);
                pin(i, p[0]);
                flag(i, 1'h1);
                w(`EIRQ_ADDR_MAIN, 8'h00);
                w(`EIRQ_ADDR_CTL3, 8'hC0);
                pin(i, 1'h0);
                flag(i, 1'h0);
            end
        end
    endtask
    task automatic t_prio;
        w(`EIRQ_ADDR_CTL2, 8'hF0);
        w(`EIRQ_ADDR_MAIN, 8'h80);
        pin(0, 1'h1);
        c({hi, lo}, 2'h0);
        w(`EIRQ_ADDR_MAIN, 8'h92);
        cy(2);
        c({hi, lo}, 2'h2);
        w(`EIRQ_ADDR_MAIN, 8'h90);
        cy(2);
        c({hi, lo}, 2'h0);
        pin(0, 1'h0);
        for (int j = 1; j < 4; j++) begin
            for (int p = 0; p < 2; p++) begin
                w(`EIRQ_ADDR_CTL2, 8'hF0 | (j == 3 ? 8'(p) << 1 : 8'h00));
                w(`EIRQ_ADDR_CTL3, (8'h04 << j) | (j < 3 ? 8'(p) << (5 + j) : 8'h00));
                pin(j, 1'h1);
                c({hi, lo}, p[0] ? 2'h2 : 2'h1);
                w(`EIRQ_ADDR_CTL3, 8'h00);
                pin(j, 1'h0);
            end
        end
    endtask
    task automatic t_wake;
        w(`EIRQ_ADDR_MAIN, 8'h00);
        slp <= 1'h1;
        pin(0, 1'h1);
        c(wake, 1'h0);
        w(`EIRQ_ADDR_MAIN, 8'h12);
        cy(2);
        c({wake, hi}, 2'h2);
        w(`EIRQ_ADDR_MAIN, 8'h92);
        cy(2);
        c(hi, 1'h1);
        w(`EIRQ_ADDR_MAIN, 8'h00);
        slp <= 1'h0;
        pin(0, 1'h0);
    endtask
    task automatic t_timer;
        w(`EIRQ_ADDR_MAIN, 8'hA0);
        w(`EIRQ_ADDR_TLO, 8'hF0);
        w(`EIRQ_ADDR_TCTL, 8'hC0);
        rc(`EIRQ_ADDR_MAIN, 8'hA0);
        cy(20);
        rc(`EIRQ_ADDR_MAIN, 8'hA4);
        c({hi, lo}, 2'h1);
        w(`EIRQ_ADDR_CTL2, 8'hF4);
        cy(2);
        c({hi, lo}, 2'h2);
        w(`EIRQ_ADDR_MAIN, 8'h84);
        cy(2);
        c({hi, lo}, 2'h0);
        // 16-bit: low-byte roll alone must not flag
        for (int k = 0; k < 2; k++) begin
            w(`EIRQ_ADDR_TCTL, 8'h00);
            w(`EIRQ_ADDR_MAIN, 8'h00);
            w(`EIRQ_ADDR_THI, k[0] ? 8'hFF : 8'h00);
            w(`EIRQ_ADDR_TLO, 8'hF0);
            w(`EIRQ_ADDR_TCTL, 8'h80);
            cy(24);
            rc(`EIRQ_ADDR_MAIN, k[0] ? 8'h04 : 8'h00);
        end
        w(`EIRQ_ADDR_TCTL, 8'h40);
        w(`EIRQ_ADDR_MAIN, 8'h00);
    endtask
    task automatic t_change;
        w(`EIRQ_ADDR_MAIN, 8'h88);
        for (int k = 4; k < 8; k++) begin
            for (int v = 1; v >= 0; v--) begin
                pin(k, v[0]);
                rc(`EIRQ_ADDR_MAIN, 8'h89);
                c({hi, lo}, 2'h1);
                w(`EIRQ_ADDR_MAIN, 8'h88);
            end
        end
        w(`EIRQ_ADDR_MAIN, 8'h80);
        pin(7, 1'h1);
        rc(`EIRQ_ADDR_MAIN, 8'h81);
        c({hi, lo}, 2'h0);
        w(`EIRQ_ADDR_CTL2, 8'hF5);
        w(`EIRQ_ADDR_MAIN, 8'h89);
        cy(2);
        c({hi, lo}, 2'h2);
        w(`EIRQ_ADDR_MAIN, 8'h00);
        pin(7, 1'h0);
    endtask
    task automatic t_entry;
        w(`EIRQ_ADDR_EVST, 8'hFF);
        w(`EIRQ_ADDR_EVMSK, 8'h40);
        w(4'h9, 8'hFF);
        rc(4'h9, 8'h00);
        // prompt and slow core answers
        for (int d = 0; d < 6; d += 5) begin
            w(`EIRQ_ADDR_MAIN, 8'h90);
            dly <= 4'(d);
            take <= 1'h1;
            // poll from the pin edge on: a prompt core pulses entry before a full pin() ends
            @(posedge mclk);
            pb[0] <= 1'h1;
            for (int n = 0; n < 40 && ent !== 1'h1; n++)
                @(posedge mclk);
            if (ent !== 1'h1)
                hang();
            take <= 1'h0;
            cy(1);
            c(opc, pc);
            c({sw, ss, sb}, ctx);
            c(irq, 1'h1);
            rc(`EIRQ_ADDR_CORE, 8'h01);
            c(full, 1'h0);
            w(`EIRQ_ADDR_MAIN, 8'h90);
            cy(8);
            rc(`EIRQ_ADDR_CORE, 8'h00);
            c(opc, 21'h0);
            pin(0, 1'h0);
        end
        w(`EIRQ_ADDR_EVMSK, 8'h00);
        cy(2);
        c(irq, 1'h0);
        w(`EIRQ_ADDR_EVMSK, 8'h40);
        w(`EIRQ_ADDR_EVST, 8'h40);
        cy(2);
        c(irq, 1'h0);
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        hang();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        rc(`EIRQ_ADDR_TCTL, 8'h40);
        rc(`EIRQ_ADDR_CTL3, 8'hC0);
        t_edges();
        t_prio();
        t_wake();
        t_timer();
        t_change();
        t_entry();
        results();
    end
endmodule
`default_nettype wire
